// >>> hdl/ep_alloc_pkg.sv
// Purpose: Shared constants for the endpoint configuration and FIFO allocator.
// Assumes: 16-bit register port, word-indexed register addresses.
// Notes:   Index 0 is the control OUT FIFO, index 1 control IN, 2..15 endpoints 1..14.
package ep_alloc_pkg;
  localparam int NUM_EP    = 16;
  localparam int NUM_CTRL  = 2;
  localparam int ADDR_W    = 6;
  localparam int DATA_W    = 16;
  localparam int CODE_W    = 4;
  localparam int ECR_W     = 8;
  localparam int LSIZE_W   = 10;
  localparam int PSIZE_W   = 11;
  localparam int BASE_W    = 16;
  localparam int IDX_W     = 4;
  localparam int DMA_W     = 5;
  localparam int STATUS_W  = 5;

  // Register addresses
  localparam logic [ADDR_W-1:0] ECR_BASE_ADDR   = 6'h00;
  localparam logic [ADDR_W-1:0] DMA_CFG_ADDR    = 6'h10;
  localparam logic [ADDR_W-1:0] STATUS_ADDR     = 6'h11;
  localparam logic [ADDR_W-1:0] TOTAL_ADDR      = 6'h12;
  localparam logic [ADDR_W-1:0] NONISO_ADDR     = 6'h13;
  localparam logic [1:0]        TBL_SEL_BASE    = 2'h2;
  localparam logic [1:0]        TBL_SEL_MAXPKT  = 2'h3;
  localparam logic [1:0]        TBL_SEL_ECR     = 2'h0;

  // Endpoint configuration register fields
  localparam int ECR_CODE_LSB = 0;
  localparam int ECR_ISO_BIT  = 4;
  localparam int ECR_DIR_BIT  = 5;
  localparam int ECR_EN_BIT   = 6;
  localparam int ECR_BULK_BIT = 7;
  localparam logic [ECR_W-1:0] ECR_RESET       = 8'h00;
  localparam logic [ECR_W-1:0] CTRL_OUT_ECR    = 8'h43;
  localparam logic [ECR_W-1:0] CTRL_IN_ECR     = 8'h63;

  // DMA configuration register fields
  localparam int DMA_IDX_LSB = 0;
  localparam int DMA_EN_BIT  = 4;
  localparam logic [DMA_W-1:0] DMA_RESET    = 5'h00;
  localparam logic [IDX_W-1:0] DMA_FIRST_EP = 4'h2;

  // Status register fields
  localparam int ST_ERR_BIT    = 0;
  localparam int ST_RSV_BIT    = 1;
  localparam int ST_POOL_BIT   = 2;
  localparam int ST_NONISO_BIT = 3;
  localparam int ST_DMA_BIT    = 4;

  // Pool limits in bytes
  localparam logic [BASE_W-1:0] POOL_LIMIT   = 16'h099E;
  localparam logic [BASE_W-1:0] NONISO_LIMIT = 16'h0200;

  localparam logic [CODE_W-1:0] NONISO_MAX_CODE = 4'h3;
  localparam logic [LSIZE_W-1:0] NONISO_SIZE_TBL [4] = '{10'h008, 10'h010, 10'h020, 10'h040};
  localparam logic [LSIZE_W-1:0] ISO_SIZE_TBL [16] = '{
    10'h010, 10'h020, 10'h030, 10'h040, 10'h060, 10'h080, 10'h0A0, 10'h0C0,
    10'h100, 10'h140, 10'h180, 10'h200, 10'h280, 10'h300, 10'h380, 10'h3FF};
endpackage

// >>> hdl/ep_size_decode.sv
// Purpose: Turns one endpoint configuration into logical and physical FIFO sizes.
// Assumes: Pure combinational, one instance per endpoint.
// Notes:   A reserved code yields zero bytes and raises rsv.
`timescale 1ns/100ps
module ep_size_decode
  import ep_alloc_pkg::*;
(
  input  wire logic [ECR_W-1:0]   endpoint_config_reg,
  input  wire logic               fixed_ctrl,
  output logic      [LSIZE_W-1:0] lsize,
  output logic      [PSIZE_W-1:0] psize,
  output logic                    rsv,
  output logic                    noniso
);
  logic              en;
  logic              iso;
  logic              dbl;
  logic [CODE_W-1:0] code;

  assign en   = endpoint_config_reg[ECR_EN_BIT];
  assign iso  = endpoint_config_reg[ECR_ISO_BIT];
  assign code = endpoint_config_reg[ECR_CODE_LSB +: CODE_W];
  // Control FIFOs are never doubled; iso and bulk always are
  assign dbl  = !fixed_ctrl && (iso || endpoint_config_reg[ECR_BULK_BIT]);                 // [RULE5] [RULE7]

  always_comb begin
    rsv   = 1'b0;
    lsize = '0;
    if (en) begin
      if (iso) begin
        lsize = ISO_SIZE_TBL[code];                                        // [RULE14]
      end else if (code <= NONISO_MAX_CODE) begin
        lsize = NONISO_SIZE_TBL[code[1:0]];                                // [RULE13]
      end else begin
        rsv = 1'b1;
      end
    end
  end

  // Disabled endpoints get no storage at all
  assign psize  = dbl ? {lsize, 1'b0} : {1'b0, lsize};                     // [RULE6] [RULE10]
  assign noniso = en && !iso;
endmodule // ep_size_decode

// >>> hdl/ep_prefix_alloc.sv
// Purpose: Packs enabled FIFOs back to back and sums pool usage.
// Assumes: Sizes arrive in endpoint order; pure combinational.
// Notes:   Carry chain length is NUM_EP adders; fine at 50 MHz.
`timescale 1ns/100ps
module ep_prefix_alloc
  import ep_alloc_pkg::*;
(
  input  wire logic [NUM_EP*PSIZE_W-1:0] psize_flat,
  input  wire logic [NUM_EP-1:0]         noniso_mask,
  output logic      [NUM_EP*BASE_W-1:0]  base_flat,
  output logic      [BASE_W-1:0]         total,
  output logic      [BASE_W-1:0]         noniso_total
);
  logic [BASE_W-1:0] run    [NUM_EP+1];
  logic [BASE_W-1:0] nrun   [NUM_EP+1];

  assign run[0]  = '0;
  assign nrun[0] = '0;

  for (genvar i = 0; i < NUM_EP; i++) begin : g_chain
    logic [BASE_W-1:0] sz;
    assign sz          = BASE_W'(psize_flat[i*PSIZE_W +: PSIZE_W]);
    // Ascending endpoint order, no gaps
    assign base_flat[i*BASE_W +: BASE_W] = run[i];                         // [RULE22]
    assign run[i+1]    = run[i] + sz;
    assign nrun[i+1]   = nrun[i] + (noniso_mask[i] ? sz : '0);
  end

  assign total        = run[NUM_EP];
  assign noniso_total = nrun[NUM_EP];
endmodule // ep_prefix_alloc

// >>> hdl/ep_fifo_alloc.sv
// Purpose: Endpoint configuration registers and shared FIFO pool allocator.
// Assumes: Single 50 MHz clock; usb_bus_reset comes from same-clock logic.
// Notes:   Results follow a register write by one clock-enabled cycle.
//
// How it works
// [RULE1] Sixteen FIFOs: control OUT and IN, then fourteen programmable endpoints.
// [RULE2] Every enabled FIFO is reachable by register-port access or the DMA path.
// [RULE3] Any endpoint may use port access; only endpoints 1..14 may use DMA.
// [RULE4] DMA target comes from a four-bit index and an enable bit.
// [RULE5] Each control FIFO is a fixed, single-buffered 64 bytes, always allocated.
// [RULE6] Double-buffer space is hidden; software only sees the logical size.
// [RULE7] Isochronous and bulk FIFOs take twice their logical size.
// [RULE8] Software keeps total physical storage at or below 2462 bytes.
// [RULE9] Software keeps non-isochronous physical storage at or below 512 bytes.
// [RULE10] Disabled endpoints get zero bytes of storage.
// [RULE11] The configured size is the largest packet the endpoint handles.
// [RULE12] Allocation depends on enable, size code and isochronous bit.
// [RULE13] Non-isochronous codes 0..3 mean 8, 16, 32, 64 bytes; others reserved.
// [RULE14] Isochronous codes give sixteen sizes from 16 up to 1023 bytes.
// [RULE15] Software must not change allocation while any FIFO holds data.
// [RULE16] A direction bit selects IN (device sends) or OUT (device receives).
// [RULE17] Software writes all sixteen configuration registers in order.
// [RULE18] Storage is assigned automatically after the configuration writes.
// [RULE19] Software acknowledges or stalls control IN depending on configuration errors.
// [RULE20] Hardware or bus reset clears programmable registers; control stays enabled.
// [RULE21] Configuration counts as valid only after enumeration completes.
// [RULE22] Enabled FIFOs are packed in endpoint order and recomputed on every write.
// [RULE23] Reserved codes or pool overflow raise a readable configuration error.
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/100ps
module ep_fifo_alloc
  import ep_alloc_pkg::*;
(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic                      clk_en,
  input  wire logic                      usb_bus_reset,
  input  wire logic [ADDR_W-1:0]         reg_addr,
  input  wire logic [DATA_W-1:0]         reg_wdata,
  input  wire logic                      reg_wr,
  input  wire logic                      reg_rd,
  output logic      [DATA_W-1:0]         reg_rdata,
  output logic      [NUM_EP-1:0]         ep_enable,
  output logic      [NUM_EP-1:0]         ep_dir_in,
  output logic      [NUM_EP*BASE_W-1:0]  ep_base,
  output logic      [NUM_EP*LSIZE_W-1:0] ep_max_pkt,
  output logic                           cfg_error,
  output logic                           dma_active,
  output logic      [IDX_W-1:0]          dma_ep,
  output logic                           dma_dir_in
);
  // Reset release
  logic rst_meta_ff;
  logic rst_sync_ff;
  logic rst_n;

  // Registers
  logic [DMA_W-1:0]            dma_cfg_ff;
  logic [ECR_W-1:0]            ecr_view   [NUM_EP];
  logic [DATA_W-1:0]           rdata_ff;
  logic [DATA_W-1:0]           nxt_rdata;

  // Allocation results
  logic [NUM_EP*PSIZE_W-1:0]   psize_flat;
  logic [NUM_EP*LSIZE_W-1:0]   lsize_flat;
  logic [NUM_EP*BASE_W-1:0]    base_flat;
  logic [NUM_EP-1:0]           rsv_mask;
  logic [NUM_EP-1:0]           noniso_mask;
  logic [NUM_EP-1:0]           en_vec;
  logic [NUM_EP-1:0]           dir_vec;
  logic [BASE_W-1:0]           total;
  logic [BASE_W-1:0]           noniso_total;

  logic [NUM_EP-1:0]           ep_enable_ff;
  logic [NUM_EP-1:0]           ep_dir_in_ff;
  logic [NUM_EP*BASE_W-1:0]    ep_base_ff;
  logic [NUM_EP*LSIZE_W-1:0]   ep_max_pkt_ff;
  logic [BASE_W-1:0]           total_ff;
  logic [BASE_W-1:0]           noniso_total_ff;
  logic                        rsv_err_ff;
  logic                        pool_err_ff;
  logic                        noniso_err_ff;
  logic                        cfg_error_ff;

  // DMA selection
  logic [IDX_W-1:0]            dma_idx;
  logic                        dma_en;
  logic                        dma_idx_ok;
  logic                        dma_active_ff;
  logic [IDX_W-1:0]            dma_ep_ff;
  logic                        dma_dir_in_ff;

  logic                        ecr_sel;
  logic [STATUS_W-1:0]         status_word;

  // The first stage feeds only the second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end
  assign rst_n = rst_sync_ff;

  assign ecr_sel = (reg_addr[ADDR_W-1:ADDR_W-2] == TBL_SEL_ECR) &&
                   (reg_addr[IDX_W] == ECR_BASE_ADDR[IDX_W]);

  // Configuration registers, one per FIFO; control entries are hard-wired
  for (genvar i = 0; i < NUM_EP; i++) begin : g_ep                        // [RULE1]
    if (i < NUM_CTRL) begin : g_ctrl
      // Writes to the control entries are ignored so they never vanish
      assign ecr_view[i] = (i == 0) ? CTRL_OUT_ECR : CTRL_IN_ECR;         // [RULE5] [RULE20]
    end else begin : g_prog
      logic [ECR_W-1:0] ecr_ff;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ecr_ff <= ECR_RESET;                                             // [RULE20]
        end else if (clk_en) begin
          if (usb_bus_reset) begin
            ecr_ff <= ECR_RESET;                                           // [RULE20]
          end else if (reg_wr && ecr_sel && reg_addr[IDX_W-1:0] == IDX_W'(i)) begin
            ecr_ff <= reg_wdata[ECR_W-1:0];                                // [RULE12] [RULE16]
          end
        end
      end
      assign ecr_view[i] = ecr_ff;
    end

    ep_size_decode u_size (
      .endpoint_config_reg        (ecr_view[i]),
      .fixed_ctrl (i < NUM_CTRL),
      .lsize      (lsize_flat[i*LSIZE_W +: LSIZE_W]),
      .psize      (psize_flat[i*PSIZE_W +: PSIZE_W]),
      .rsv        (rsv_mask[i]),
      .noniso     (noniso_mask[i])
    );

    assign en_vec[i]  = ecr_view[i][ECR_EN_BIT];
    assign dir_vec[i] = ecr_view[i][ECR_DIR_BIT];                          // [RULE16]
  end

  ep_prefix_alloc u_alloc (
    .psize_flat   (psize_flat),
    .noniso_mask  (noniso_mask),
    .base_flat    (base_flat),
    .total        (total),
    .noniso_total (noniso_total)
  );

  // DMA configuration register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_cfg_ff <= DMA_RESET;
    end else if (clk_en && reg_wr && reg_addr == DMA_CFG_ADDR) begin
      dma_cfg_ff <= reg_wdata[DMA_W-1:0];                                  // [RULE4]
    end
  end

  assign dma_idx    = dma_cfg_ff[DMA_IDX_LSB +: IDX_W];
  assign dma_en     = dma_cfg_ff[DMA_EN_BIT];
  // Indices below the first programmable endpoint select a control FIFO
  assign dma_idx_ok = (dma_idx >= DMA_FIRST_EP);                           // [RULE3]

  // DMA path follows the selected endpoint's enable and direction
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dma_active_ff <= 1'b0;
      dma_ep_ff     <= '0;
      dma_dir_in_ff <= 1'b0;
    end else if (clk_en) begin
      dma_active_ff <= dma_en && dma_idx_ok && en_vec[dma_idx];           // [RULE2] [RULE4]
      dma_ep_ff     <= dma_idx;
      dma_dir_in_ff <= dir_vec[dma_idx];                                   // [RULE16]
    end
  end

  // Recomputed every clock-enabled cycle, so any write lands here without software help
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ep_enable_ff  <= '0;
      ep_dir_in_ff  <= '0;
      ep_base_ff    <= '0;
      ep_max_pkt_ff <= '0;
    end else if (clk_en) begin
      ep_enable_ff  <= en_vec;                                             // [RULE2] [RULE10]
      ep_dir_in_ff  <= dir_vec;
      ep_base_ff    <= base_flat;                                          // [RULE18] [RULE22]
      ep_max_pkt_ff <= lsize_flat;                                         // [RULE11] [RULE6]
    end
  end

  // Pool checks; the limits are the software's to keep, this only reports
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      total_ff        <= '0;
      noniso_total_ff <= '0;
      rsv_err_ff      <= 1'b0;
      pool_err_ff     <= 1'b0;
      noniso_err_ff   <= 1'b0;
      cfg_error_ff    <= 1'b0;
    end else if (clk_en) begin
      total_ff        <= total;
      noniso_total_ff <= noniso_total;
      rsv_err_ff      <= |rsv_mask;                                        // [RULE23] [RULE13]
      pool_err_ff     <= total > POOL_LIMIT;                               // [RULE23] [RULE8]
      noniso_err_ff   <= noniso_total > NONISO_LIMIT;                      // [RULE23] [RULE9]
      cfg_error_ff    <= (|rsv_mask) || (total > POOL_LIMIT) ||
                         (noniso_total > NONISO_LIMIT);                    // [RULE23]
    end
  end

  always_comb begin
    status_word                = '0;
    status_word[ST_ERR_BIT]    = cfg_error_ff;
    status_word[ST_RSV_BIT]    = rsv_err_ff;
    status_word[ST_POOL_BIT]   = pool_err_ff;
    status_word[ST_NONISO_BIT] = noniso_err_ff;
    status_word[ST_DMA_BIT]    = dma_active_ff;
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    nxt_rdata = '0;
    if (reg_addr == DMA_CFG_ADDR) begin
      nxt_rdata = DATA_W'(dma_cfg_ff);
    end else if (reg_addr == STATUS_ADDR) begin
      nxt_rdata = DATA_W'(status_word);                                    // [RULE23]
    end else if (reg_addr == TOTAL_ADDR) begin
      nxt_rdata = total_ff;
    end else if (reg_addr == NONISO_ADDR) begin
      nxt_rdata = noniso_total_ff;
    end else if (ecr_sel) begin
      nxt_rdata = DATA_W'(ecr_view[reg_addr[IDX_W-1:0]]);
    end else if (reg_addr[ADDR_W-1:ADDR_W-2] == TBL_SEL_BASE) begin
      nxt_rdata = ep_base_ff[reg_addr[IDX_W-1:0]*BASE_W +: BASE_W];
    end else if (reg_addr[ADDR_W-1:ADDR_W-2] == TBL_SEL_MAXPKT) begin
      // Logical size only; the doubled physical share stays hidden
      nxt_rdata = DATA_W'(ep_max_pkt_ff[reg_addr[IDX_W-1:0]*LSIZE_W +: LSIZE_W]); // [RULE6]
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= '0;
    end else if (clk_en) begin
      rdata_ff <= reg_rd ? nxt_rdata : '0;
    end
  end

  assign reg_rdata  = rdata_ff;
  assign ep_enable  = ep_enable_ff;
  assign ep_dir_in  = ep_dir_in_ff;
  assign ep_base    = ep_base_ff;
  assign ep_max_pkt = ep_max_pkt_ff;
  assign cfg_error  = cfg_error_ff;
  assign dma_active = dma_active_ff;
  assign dma_ep     = dma_ep_ff;
  assign dma_dir_in = dma_dir_in_ff;
endmodule // ep_fifo_alloc

// >>> tb/ep_fifo_alloc_chk.sv
// Purpose: Port-level assertions for the endpoint FIFO allocator.
// Assumes: One clock domain; checks are off while arst_n is low.
// Notes:   Bound to every ep_fifo_alloc instance.
`timescale 1ns/100ps
module ep_fifo_alloc_chk
  import ep_alloc_pkg::*;
(
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic                      clk_en,
  input wire logic                      usb_bus_reset,
  input wire logic [ADDR_W-1:0]         reg_addr,
  input wire logic [DATA_W-1:0]         reg_wdata,
  input wire logic                      reg_wr,
  input wire logic                      reg_rd,
  input wire logic [DATA_W-1:0]         reg_rdata,
  input wire logic [NUM_EP-1:0]         ep_enable,
  input wire logic [NUM_EP-1:0]         ep_dir_in,
  input wire logic [NUM_EP*BASE_W-1:0]  ep_base,
  input wire logic [NUM_EP*LSIZE_W-1:0] ep_max_pkt,
  input wire logic                      cfg_error,
  input wire logic                      dma_active,
  input wire logic [IDX_W-1:0]          dma_ep,
  input wire logic                      dma_dir_in
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_rdata_idle:
    assert property (!$past(reg_rd) && $past(clk_en) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside answer cycle");
  a_ctrl_read:
    assert property (reg_rd && clk_en && reg_addr == 6'h00 |=> reg_rdata == 16'h0043)
    else $error("control OUT config read wrong");
  a_ctrl_stays_on:
    assert property ($past(ep_enable[1:0]) == 2'b11 |-> ep_enable[1:0] == 2'b11)
    else $error("control FIFO became disabled");
  a_ctrl_fixed:
    assert property (ep_enable[1] |-> ep_base[31:0] == 32'h0040_0000
                     && ep_max_pkt[19:0] == {10'h040, 10'h040})
    else $error("control FIFO base or size wrong");
  a_ctrl_dir:
    assert property (ep_enable[1] |-> ep_dir_in[1:0] == 2'b10)
    else $error("control FIFO direction wrong");
  a_pack_first:
    assert property (ep_enable[2] |-> ep_base[47:32] == 16'h0080)
    else $error("first programmable FIFO not after control FIFOs");
  a_dma_target:
    assert property (dma_active |-> dma_ep >= DMA_FIRST_EP && ep_enable[dma_ep])
    else $error("DMA active on invalid FIFO");
  a_dma_dir:
    assert property (dma_active |-> dma_dir_in == ep_dir_in[dma_ep])
    else $error("DMA direction differs from FIFO direction");
  a_bus_reset:
    assert property (usb_bus_reset && clk_en ##1 clk_en && !reg_wr |=> ep_enable == 16'h0003)
    else $error("bus reset left programmable FIFOs enabled");
  a_freeze_hold:
    assert property (!clk_en |=> $stable(ep_enable) && $stable(ep_base) && $stable(cfg_error))
    else $error("allocation changed while clock enable low");
endmodule // ep_fifo_alloc_chk

bind ep_fifo_alloc ep_fifo_alloc_chk i_ep_fifo_alloc_chk (.clk, .arst_n, .clk_en,
  .usb_bus_reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ep_enable,
  .ep_dir_in, .ep_base, .ep_max_pkt, .cfg_error, .dma_active, .dma_ep, .dma_dir_in);

// >>> tb/fw_host_model.sv
// Purpose: Firmware model driving the register port of the allocator.
// Assumes: Strobes are one cycle; read data is taken the cycle after.
// Notes:   Holds no FIFO data, so reallocation never loses packets.
`timescale 1ns/100ps
module fw_host_model
  import ep_alloc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] reg_rdata,
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_wr,
  output logic                   reg_rd
);
  initial begin
    reg_addr  = 6'h00;
    reg_wdata = 16'h0000;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    // Stale data would hide a late sampling slip
    reg_wdata <= ~v;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  // Callers keep pool use in bounds except on purpose
  task automatic program_all(input logic [ECR_W-1:0] e [NUM_EP], output logic ok);
    logic [DATA_W-1:0] st;
    for (int i = 0; i < NUM_EP; i++)
      wr(ECR_BASE_ADDR + ADDR_W'(i), {8'h00, e[i]});
    repeat (3) @(posedge clk);
    // Result judged only after the whole sequence
    rd(STATUS_ADDR, st);
    ok = !st[ST_ERR_BIT];
  endtask
endmodule // fw_host_model

// >>> tb/ep_fifo_alloc_tb.sv
// Purpose: Self-checking bench for the endpoint FIFO allocator.
// Assumes: 50 MHz clock; firmware model owns the register port.
// Notes:   Expected sizes are worked out here, not read from the design.
`timescale 1ns/100ps
module ep_fifo_alloc_tb
  import ep_alloc_pkg::*;
;
  logic                      clk;
  logic                      arst_n;
  logic                      clk_en;
  logic                      usb_bus_reset;
  logic [ADDR_W-1:0]         reg_addr;
  logic [DATA_W-1:0]         reg_wdata;
  logic                      reg_wr;
  logic                      reg_rd;
  logic [DATA_W-1:0]         reg_rdata;
  logic [NUM_EP-1:0]         ep_enable;
  logic [NUM_EP-1:0]         ep_dir_in;
  logic [NUM_EP*BASE_W-1:0]  ep_base;
  logic [NUM_EP*LSIZE_W-1:0] ep_max_pkt;
  logic                      cfg_error;
  logic                      dma_active;
  logic [IDX_W-1:0]          dma_ep;
  logic                      dma_dir_in;
  logic [DATA_W-1:0]         d;
  logic [ECR_W-1:0]          endpoint_config_reg [NUM_EP];
  logic                      ok;
  int                        mismatches;
  int                        comparisons;

  ep_fifo_alloc i_ep_fifo_alloc (.clk, .arst_n, .clk_en, .usb_bus_reset, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .ep_enable, .ep_dir_in, .ep_base,
    .ep_max_pkt, .cfg_error, .dma_active, .dma_ep, .dma_dir_in);
  fw_host_model i_fw_host_model (.clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd);

  task automatic chk(input string n, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rchk(input string n, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_fw_host_model.rd(a, d);
    chk(n, e, d);
  endtask
  // Results land one edge after the write task returns; two more give margin
  task automatic cfg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
    i_fw_host_model.wr(a, v);
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic t_reset;
    rchk("ecr0", 6'h00, 16'h0043);
    chk("enable", 16'h0003, ep_enable);
    rchk("ecr1", 6'h01, 16'h0063);
    rchk("ecr2", 6'h02, 16'h0000);
    rchk("total", TOTAL_ADDR, 16'h0080);
    rchk("noniso", NONISO_ADDR, 16'h0080);
    rchk("status", STATUS_ADDR, 16'h0000);
    rchk("unmapped", 6'h14, 16'h0000);
    cfg(6'h00, 16'h0000);
    rchk("ecr0_ro", 6'h00, 16'h0043);
  endtask

  task automatic t_noniso;
    logic [DATA_W-1:0] sz;
    for (int c = 0; c < 16; c++) begin
      sz = (c < 4) ? 16'(8 << c) : 16'h0000;
      cfg(6'h02, 16'(8'hC0 | c));
      rchk("maxpkt", 6'h32, sz);
      rchk("total", TOTAL_ADDR, 16'h0080 + 2 * sz);
      rchk("status", STATUS_ADDR, (c < 4) ? 16'h0000 : 16'h0003);
      chk("cfg_error", (c < 4) ? 16'h0000 : 16'h0001, 16'(cfg_error));
    end
    cfg(6'h02, 16'h0041);
    rchk("single", TOTAL_ADDR, 16'h0090);
  endtask

  task automatic t_iso;
    logic [DATA_W-1:0] tbl [16] = '{16'h0010, 16'h0020, 16'h0030, 16'h0040, 16'h0060,
      16'h0080, 16'h00A0, 16'h00C0, 16'h0100, 16'h0140, 16'h0180, 16'h0200, 16'h0280,
      16'h0300, 16'h0380, 16'h03FF};
    cfg(6'h02, 16'h0000);
    for (int c = 0; c < 16; c++) begin
      cfg(6'h03, 16'(8'h50 | c));
      rchk("iso_maxpkt", 6'h33, tbl[c]);
      rchk("iso_total", TOTAL_ADDR, 16'h0080 + 2 * tbl[c]);
      rchk("iso_noniso", NONISO_ADDR, 16'h0080);
    end
  endtask

  task automatic t_limits;
    endpoint_config_reg = '{2: 8'h5F, 3: 8'h41, 4: 8'h61, 5: 8'hC3, 6: 8'hE3, default: 8'h00};
    i_fw_host_model.program_all(endpoint_config_reg, ok);
    chk("fit_ok", 16'h0001, 16'(ok));
    rchk("total", TOTAL_ADDR, 16'h099E);
    rchk("noniso", NONISO_ADDR, 16'h01A0);
    rchk("base6", 6'h26, 16'h091E);
    chk("base5", 16'h089E, ep_base[5*BASE_W +: BASE_W]);
    chk("enable", 16'h007F, ep_enable);
    chk("dir", 16'h0052, ep_dir_in);
    chk("maxpkt2", 16'h03FF, 16'(ep_max_pkt[2*LSIZE_W +: LSIZE_W]));
    cfg(6'h07, 16'h00C0);
    rchk("pool_err", STATUS_ADDR, 16'h0005);
    cfg(6'h02, 16'h001F);
    chk("base3", 16'h0080, ep_base[3*BASE_W +: BASE_W]);
    cfg(6'h08, 16'h00C3);
    rchk("noniso_err", STATUS_ADDR, 16'h0009);
    rchk("noniso", NONISO_ADDR, 16'h0230);
  endtask

  task automatic t_dma;
    logic [DATA_W-1:0] v [5] = '{16'h0014, 16'h0013, 16'h0011, 16'h0012, 16'h0004};
    logic [1:0]        x [5] = '{2'b11, 2'b10, 2'b00, 2'b00, 2'b00};
    for (int k = 0; k < 5; k++) begin
      cfg(DMA_CFG_ADDR, v[k]);
      chk("dma", 16'(x[k]), 16'({dma_active, dma_active & dma_dir_in}));
      chk("dma_ep", 16'(v[k][3:0]), 16'(dma_ep));
      rchk("dma_st", STATUS_ADDR, 16'h0009 | {11'h000, x[k][1], 4'h0});
    end
  endtask

  task automatic t_resets;
    cfg(6'h02, 16'h0043);
    @(posedge clk);
    usb_bus_reset <= 1'b1;
    @(posedge clk);
    usb_bus_reset <= 1'b0;
    rchk("ecr2", 6'h02, 16'h0000);
    chk("enable", 16'h0003, ep_enable);
    rchk("dma_kept", DMA_CFG_ADDR, 16'h0004);
    @(posedge clk);
    clk_en <= 1'b0;
    i_fw_host_model.wr(6'h02, 16'h0043);
    clk_en <= 1'b1;
    rchk("frozen", 6'h02, 16'h0000);
    // Leave real state behind so the hardware reset has something to clear
    cfg(6'h04, 16'h0061);
    cfg(DMA_CFG_ADDR, 16'h0014);
    chk("pre_dma", 16'h0001, 16'(dma_active));
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    rchk("hw_ecr4", 6'h04, 16'h0000);
    rchk("hw_dma", DMA_CFG_ADDR, 16'h0000);
    chk("hw_enable", 16'h0003, ep_enable);
    chk("hw_dma_act", 16'h0000, 16'(dma_active));
  endtask

  task automatic results;
    $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    arst_n        = 1'b0;
    clk_en        = 1'b1;
    usb_bus_reset = 1'b0;
    mismatches    = 0;
    comparisons   = 0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    t_reset;
    t_noniso;
    t_iso;
    t_limits;
    t_dma;
    t_resets;
    results;
  end
  // About 530 cycles are needed; the 20000-cycle limit allows over thirty times that
  initial begin
    #400000;
    mismatches++;
    results;
  end
endmodule // ep_fifo_alloc_tb
